// ### hw/ecpmc_cfg.svh
`ifndef ECPMC_CFG_SVH
`define ECPMC_CFG_SVH
`define ECPMC_OFS_DATA 11'h000
`define ECPMC_OFS_STAT 11'h001
`define ECPMC_OFS_CTRL 11'h002
`define ECPMC_OFS_FIFO 11'h400
`define ECPMC_OFS_CFGA 11'h400
`define ECPMC_OFS_CFGB 11'h401
`define ECPMC_OFS_ECR 11'h402
`define ECPMC_MODE_SPP 3'h0
`define ECPMC_MODE_BIDIR 3'h1
`define ECPMC_MODE_PFIFO 3'h2
`define ECPMC_MODE_ECP 3'h3
`define ECPMC_MODE_EPP 3'h4
`define ECPMC_MODE_TEST 3'h6
`define ECPMC_MODE_CFG 3'h7
`define ECPMC_ECR_MODE_HI 7
`define ECPMC_ECR_MODE_LO 5
`define ECPMC_ECR_FMASK 4
`define ECPMC_ECR_DMA_REQUEST_ENABLE 3
`define ECPMC_ECR_HOLD 2
`define ECPMC_ECR_FULL 1
`define ECPMC_ECR_EMPTY 0
`define ECPMC_DCR_DIR 5
`define ECPMC_DCR_ACKIE 4
`define ECPMC_ECR_RST 8'h15
`define ECPMC_CFGA_VAL 8'h10
`define ECPMC_CTRL_IDLE 4'hf
`define ECPMC_SETUP_NS 10
`define ECPMC_SETUP_CYC ((`ECPMC_SETUP_NS + 4) / 5)
`endif

// ### hw/ecpmc_pkg.sv
package ecpmc_pkg;
  typedef enum logic [2:0] {
    HS_IDLE, HS_SETUP, HS_STROBE, HS_BUSY_WAIT, HS_REV_WAIT
  } ecpmc_hs_t;
  typedef logic [2:0] ecpmc_mode_t;
endpackage

// ### hw/ecpmc_fifo_if.sv
`timescale 1ns/1ps
interface ecpmc_fifo_if #(parameter int W = 9, parameter int CW = 3);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  logic [CW-1:0] count;
  logic flush;
  modport store(input push_valid, push_data, pop_ready, flush,
                output push_ready, pop_valid, pop_data, count);
  modport user(output push_valid, push_data, pop_ready, flush,
               input push_ready, pop_valid, pop_data, count);
endinterface

// ### hw/ecpmc_fifo.sv
`timescale 1ns/1ps
module ecpmc_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  ecpmc_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || $bits(f.count) != AW + 1)
      $error("ecpmc_fifo: depth must be a power of two");
  end
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic do_push;
  logic do_pop;
  assign f.count = wr_q - rd_q;
  assign f.push_ready = (f.count != (AW + 1)'(DEPTH));
  assign f.pop_valid = (wr_q != rd_q);
  assign f.pop_data = mem_q[rd_q[AW-1:0]];
  assign do_push = f.push_valid && f.push_ready && !f.flush;
  assign do_pop = f.pop_valid && f.pop_ready && !f.flush;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (f.flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (do_push) wr_q <= wr_q + 1'b1;
      if (do_pop) rd_q <= rd_q + 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (do_push) mem_q[wr_q[AW-1:0]] <= f.push_data;
  end
endmodule

// ### hw/ecpmc_sync.sv
`timescale 1ns/1ps
module ecpmc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  // a bit moves only once stages two and three agree
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      level <= RST;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level <= (s2_q & s3_q) | (level & (s2_q | s3_q));
    end
  end
endmodule

// ### hw/ecpmc_top.sv
// Overview of operation
// RULE1: ecr bits 7..5 hold the mode
// RULE2: fault falling edge interrupts unless masked
// RULE3: unmasking with fault low interrupts
// RULE4: dma requests need enable and hold clear
// RULE5: hold blocks dma, service irqs; writes silent
// RULE6: service irq sets hold; software clears
// RULE7: dma terminal count fires service irq
// RULE8: pio forward fires on free space threshold
// RULE9: pio reverse fires on fill threshold
// RULE10: ecr bit1 full, bit0 empty
// RULE11: mode 000 flushes fifo, open collector
// RULE12: mode 001 direction tristates, live reads
// RULE13: mode 010 sends fifo by compatible handshake
// RULE14: mode 011 ecp forward and reverse transfer
// RULE15: mode 100 epp only if option on
// RULE16: mode 110 fifo never sent on port
// RULE17: mode 111 shows config registers
// RULE18: modes 010, 011 start auto transfer
// RULE19: extended modes only exit to 000/001
// RULE20: control lines deassert before mode leaves
// RULE21: leaving reverse drops bytes, autofeed off
// RULE22: host clears direction, strobe, autofeed first
// RULE23: clearing hold with condition true fires
// RULE24: threshold is programmed value plus one
// RULE25: interrupts are single cycle pulses
`timescale 1ns/1ps
`include "ecpmc_cfg.svh"
module ecpmc_top import ecpmc_pkg::*; #(
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [10:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata_q,
  input wire logic dma_ack,
  input wire logic dma_tc,
  output logic dma_req_q,
  input wire logic epp_option,
  input wire logic [3:0] threshold_setting,
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out_q,
  output logic pd_oe_n_q,
  input wire logic busy,
  input wire logic ack_n,
  input wire logic fault_n,
  output logic [3:0] ctrl_n_q,
  output logic ctrl_oc_q,
  output logic epp_sel_q,
  output logic irq_q
);
  localparam int CW = $clog2(DEPTH) + 1;
  initial begin
    if (DEPTH < 2 || DEPTH > 16) $error("ecpmc_top: depth must be 2..16");
  end
  // =====================================================
  // decode helpers
  function automatic logic fifo_mode(input ecpmc_mode_t m);
    fifo_mode = (m == `ECPMC_MODE_PFIFO) || (m == `ECPMC_MODE_ECP) ||
                (m == `ECPMC_MODE_TEST);
  endfunction
  function automatic logic base_mode(input ecpmc_mode_t m);
    base_mode = (m == `ECPMC_MODE_SPP) || (m == `ECPMC_MODE_BIDIR);
  endfunction
  // =====================================================
  // pin synchronisers
  logic [10:0] pins_s;
  ecpmc_sync #(.W(11), .RST(11'h600)) u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pin({fault_n, ack_n, busy, pd_in}),
    .level(pins_s)
  );
  logic [7:0] pd_s;
  logic busy_s;
  logic ack_n_s;
  logic fault_n_s;
  assign pd_s = pins_s[7:0];
  assign busy_s = pins_s[8];
  assign ack_n_s = pins_s[9];
  assign fault_n_s = pins_s[10];
  // =====================================================
  // fifo
  ecpmc_fifo_if #(.W(9), .CW(CW)) fq ();
  ecpmc_fifo #(.W(9), .DEPTH(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .f(fq)
  );
  // =====================================================
  // register state
  ecpmc_mode_t mode_q;
  ecpmc_mode_t pend_q;
  logic leave_q;
  logic fmask_q;
  logic dma_en_q;
  logic hold_q;
  logic [5:0] dcr_q;
  logic [7:0] data_q;
  logic [8:0] last_q;
  logic fault_prev_q;
  ecpmc_hs_t hs_q;
  logic [8:0] hs_byte_q;
  logic [3:0] hs_cnt_q;
  logic dir_eff;
  logic fwd_auto;
  logic rev_auto;
  logic wr_ecr;
  logic wr_mode_ok;
  logic host_push;
  logic host_pop;
  logic hs_push;
  logic hs_pop;
  logic cond_dma;
  logic cond_tx;
  logic cond_rx;
  logic svc_fire;
  logic fault_evt;
  ecpmc_mode_t wmode;
  assign wmode = bus_wdata[`ECPMC_ECR_MODE_HI:`ECPMC_ECR_MODE_LO];
  assign wr_ecr = bus_wr && !dma_ack && (bus_addr == `ECPMC_OFS_ECR);
  // RULE19: exit legality
  assign wr_mode_ok = base_mode(mode_q) || base_mode(wmode);
  // modes 000 and 010 always drive forward
  assign dir_eff = dcr_q[`ECPMC_DCR_DIR] && (mode_q != `ECPMC_MODE_SPP) &&
                   (mode_q != `ECPMC_MODE_PFIFO);
  // RULE18: auto transfer in 010 and 011
  assign fwd_auto = !leave_q && !dir_eff &&
                    ((mode_q == `ECPMC_MODE_PFIFO) || (mode_q == `ECPMC_MODE_ECP));
  assign rev_auto = !leave_q && dir_eff && (mode_q == `ECPMC_MODE_ECP);
  // =====================================================
  // mode and ecr fields
  // RULE1: mode field written
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= `ECPMC_MODE_SPP;
      pend_q <= `ECPMC_MODE_SPP;
      leave_q <= 1'b0;
    end else begin
      leave_q <= 1'b0;
      if (leave_q) begin
        mode_q <= pend_q;
      end else if (wr_ecr && wr_mode_ok && wmode != mode_q) begin
        // RULE20: one quiet cycle first
        if (!base_mode(mode_q)) begin
          pend_q <= wmode;
          leave_q <= 1'b1;
        end else begin
          mode_q <= wmode;
        end
      end
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fmask_q <= 1'b1;
      dma_en_q <= 1'b0;
    end else if (wr_ecr) begin
      fmask_q <= bus_wdata[`ECPMC_ECR_FMASK];
      dma_en_q <= bus_wdata[`ECPMC_ECR_DMA_REQUEST_ENABLE];
    end
  end
  // RULE6: hardware set beats software clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) hold_q <= 1'b1;
    else if (svc_fire) hold_q <= 1'b1;
    else if (wr_ecr) hold_q <= bus_wdata[`ECPMC_ECR_HOLD];
  end
  // =====================================================
  // data and control registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dcr_q <= '0;
      data_q <= '0;
    end else if (bus_wr && !dma_ack) begin
      if (bus_addr == `ECPMC_OFS_CTRL) begin
        dcr_q[4:0] <= bus_wdata[4:0];
        // RULE19: direction only in base modes
        if (base_mode(mode_q)) dcr_q[`ECPMC_DCR_DIR] <= bus_wdata[`ECPMC_DCR_DIR];
      end
      if (bus_addr == `ECPMC_OFS_DATA && mode_q != `ECPMC_MODE_ECP) data_q <= bus_wdata;
    end
  end
  // =====================================================
  // fifo steering
  // RULE14: command and data share one fifo, tag bit 8
  assign host_push = bus_wr && fifo_mode(mode_q) && !leave_q && !rev_auto &&
                     (dma_ack || bus_addr == `ECPMC_OFS_FIFO ||
                      (bus_addr == `ECPMC_OFS_DATA && mode_q == `ECPMC_MODE_ECP));
  assign host_pop = bus_rd && !fwd_auto && !leave_q &&
                    ((mode_q == `ECPMC_MODE_ECP) || (mode_q == `ECPMC_MODE_TEST)) &&
                    (dma_ack || bus_addr == `ECPMC_OFS_FIFO);
  assign fq.push_valid = rev_auto ? hs_push : host_push;
  assign fq.push_data = rev_auto ? {1'b0, pd_s} :
                        {(!dma_ack && bus_addr == `ECPMC_OFS_DATA), bus_wdata};
  assign fq.pop_ready = fwd_auto ? hs_pop : host_pop;
  // RULE11: fifo held reset in 000
  // RULE21: extra reverse bytes discarded on exit
  assign fq.flush = (mode_q == `ECPMC_MODE_SPP) || leave_q;
  // =====================================================
  // automatic handshake
  assign hs_pop = (hs_q == HS_IDLE) && fq.pop_valid;
  assign hs_push = (hs_q == HS_IDLE) && !ack_n_s;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hs_q <= HS_IDLE;
      hs_byte_q <= '0;
      hs_cnt_q <= '0;
    end else if (!fwd_auto && !rev_auto) begin
      // RULE16: test mode never reaches the port
      hs_q <= HS_IDLE;
    end else begin
      case (hs_q)
        HS_IDLE: begin
          // RULE13: compatible forward send
          if (fwd_auto && fq.pop_valid) begin
            hs_byte_q <= fq.pop_data;
            hs_cnt_q <= 4'(`ECPMC_SETUP_CYC);
            hs_q <= HS_SETUP;
          end else if (rev_auto && !ack_n_s && fq.push_ready) begin
            // RULE14: reverse byte captured
            hs_q <= HS_REV_WAIT;
          end
        end
        HS_SETUP: begin
          if (hs_cnt_q <= 4'h1) hs_q <= HS_STROBE;
          else hs_cnt_q <= hs_cnt_q - 4'h1;
        end
        HS_STROBE: begin
          if (busy_s) hs_q <= HS_BUSY_WAIT;
        end
        HS_BUSY_WAIT: begin
          if (!busy_s) hs_q <= HS_IDLE;
        end
        HS_REV_WAIT: begin
          if (ack_n_s) hs_q <= HS_IDLE;
        end
        default: hs_q <= HS_IDLE;
      endcase
    end
  end
  // =====================================================
  // service and fault events
  // RULE24: level is setting plus one
  assign cond_tx = !dma_en_q && !dir_eff &&
                   (int'(DEPTH) - int'(fq.count) > int'(threshold_setting));
  assign cond_rx = !dma_en_q && dir_eff && (int'(fq.count) > int'(threshold_setting));
  // RULE7: terminal count
  assign cond_dma = dma_en_q && dma_tc;
  // RULE5: hold blocks the service events
  // RULE8: forward pio threshold
  // RULE9: reverse pio threshold
  // RULE23: level check fires right after clear
  assign svc_fire = !hold_q && fifo_mode(mode_q) && !leave_q &&
                    (cond_dma || cond_tx || cond_rx);
  // RULE2: falling fault, ecp mode only
  // RULE3: unmask with fault already low
  assign fault_evt = (mode_q == `ECPMC_MODE_ECP) &&
                     ((!fmask_q && fault_prev_q && !fault_n_s) ||
                      (wr_ecr && fmask_q && !bus_wdata[`ECPMC_ECR_FMASK] && !fault_n_s));
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fault_prev_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      fault_prev_q <= fault_n_s;
      // RULE25: one cycle pulse per event
      irq_q <= svc_fire || fault_evt;
    end
  end
  // =====================================================
  // dma request
  // RULE4: enable and hold gate requests
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) dma_req_q <= 1'b0;
    else dma_req_q <= dma_en_q && !hold_q && fifo_mode(mode_q) && !leave_q &&
                      (dir_eff ? fq.pop_valid : fq.push_ready);
  end
  // =====================================================
  // port pins
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_n_q <= `ECPMC_CTRL_IDLE;
      ctrl_oc_q <= 1'b1;
      pd_out_q <= '0;
      pd_oe_n_q <= 1'b0;
      epp_sel_q <= 1'b0;
    end else begin
      // RULE11: open collector only in 000
      ctrl_oc_q <= (mode_q == `ECPMC_MODE_SPP);
      // RULE12: direction tristates the data lines
      pd_oe_n_q <= dir_eff;
      // RULE15: epp needs the chip option
      epp_sel_q <= (mode_q == `ECPMC_MODE_EPP) && epp_option;
      pd_out_q <= fwd_auto ? hs_byte_q[7:0] : data_q;
      // RULE20: control lines released in the quiet cycle
      // RULE21: autofeed dropped mid transfer
      if (leave_q) begin
        ctrl_n_q <= `ECPMC_CTRL_IDLE;
      end else if (fwd_auto || rev_auto) begin
        ctrl_n_q <= {~dcr_q[3], dcr_q[2],
                     ~((fwd_auto && hs_byte_q[8] && hs_q != HS_IDLE) ||
                       (rev_auto && hs_q == HS_REV_WAIT)),
                     ~(hs_q == HS_STROBE)};
      end else begin
        // RULE22: host leaves strobe and autofeed clear
        ctrl_n_q <= {~dcr_q[3], dcr_q[2], ~dcr_q[1], ~dcr_q[0]};
      end
    end
  end
  // =====================================================
  // register reads
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata_q <= '0;
      last_q <= '0;
    end else if (bus_rd) begin
      if (host_pop) begin
        // empty test reads repeat the last byte
        if (fq.pop_valid) last_q <= fq.pop_data;
        bus_rdata_q <= fq.pop_valid ? fq.pop_data[7:0] : last_q[7:0];
      end else begin
        case (bus_addr)
          // RULE12: live data lines when reading
          `ECPMC_OFS_DATA: bus_rdata_q <= dir_eff ? pd_s : data_q;
          `ECPMC_OFS_STAT: bus_rdata_q <= {~busy_s, ack_n_s, 2'b00, fault_n_s, 3'b000};
          `ECPMC_OFS_CTRL: bus_rdata_q <= {2'b00, dcr_q};
          // RULE17: config registers in 111
          `ECPMC_OFS_CFGA: bus_rdata_q <=
              (mode_q == `ECPMC_MODE_CFG) ? `ECPMC_CFGA_VAL : 8'h00;
          `ECPMC_OFS_CFGB: bus_rdata_q <=
              (mode_q == `ECPMC_MODE_CFG) ? {1'b0, irq_q, 6'h00} : 8'h00;
          // RULE10: full and empty status
          `ECPMC_OFS_ECR: bus_rdata_q <= {mode_q, fmask_q, dma_en_q, hold_q,
                                          !fq.push_ready, !fq.pop_valid};
          default: bus_rdata_q <= 8'h00;
        endcase
      end
    end
  end
  // =====================================================
  // checks
  a_hold_on_fire: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE6
    svc_fire |=> hold_q && irq_q)
    else $error("hold not set after service event");
  a_irq_pulse_one: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE25
    irq_q && !$past(fault_evt) |=> !irq_q || $past(fault_evt))
    else $error("service irq longer than one cycle");
  a_hold_write_silent: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE5
    wr_ecr && bus_wdata[`ECPMC_ECR_HOLD] && !svc_fire && !fault_evt |=> hold_q && !irq_q)
    else $error("hold write raised interrupt");
  a_dma_gate: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE4
    dma_req_q |-> $past(dma_en_q) && !$past(hold_q))
    else $error("dma request without enable");
  a_empty_flag: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE10
    bus_rd && !dma_ack && bus_addr == `ECPMC_OFS_ECR |=>
      bus_rdata_q[0] == $past(!fq.pop_valid) && bus_rdata_q[1] == $past(!fq.push_ready))
    else $error("ecr full or empty wrong");
  a_mode_exit: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE19
    $changed(mode_q) |-> base_mode($past(mode_q)) || base_mode(mode_q))
    else $error("illegal mode transition");
  a_leave_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE20
    leave_q |=> ctrl_n_q == `ECPMC_CTRL_IDLE && base_mode(mode_q))
    else $error("control lines active at mode exit");
  a_spp_flush: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE11
    mode_q == `ECPMC_MODE_SPP |=> fq.count == '0 && ctrl_oc_q && !pd_oe_n_q)
    else $error("spp mode not holding fifo reset");
  a_fault_irq: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE2
    fault_evt |=> irq_q)
    else $error("fault event lost");
  a_tc_fire: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE7
    dma_tc && dma_en_q && !hold_q && fifo_mode(mode_q) && !leave_q |=> hold_q ##0 irq_q)
    else $error("terminal count missed");
  c_service: cover property (@(posedge clk_sys) disable iff (!reset_n) svc_fire);
  c_leave: cover property (@(posedge clk_sys) disable iff (!reset_n) leave_q);
  c_fwd_byte: cover property (@(posedge clk_sys) disable iff (!reset_n)
    hs_q == HS_STROBE ##[1:20] hs_q == HS_IDLE);
  c_rev_byte: cover property (@(posedge clk_sys) disable iff (!reset_n)
    rev_auto && hs_push && fq.push_ready);
endmodule

// ### test/ecpmc_periph.sv
`timescale 1ns/1ps
// ==========
// peripheral stand-in on the parallel link
module ecpmc_periph (
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic [3:0] ctrl_n,
  input wire logic [7:0] pd_out,
  input wire logic pd_oe_n,
  input wire logic [7:0] rv_base,
  input wire logic [3:0] rev_n,
  output logic busy,
  output logic ack_n,
  output logic [7:0] pd_in,
  output logic [7:0] got,
  output logic got_cmd,
  output int n_got,
  output int n_sent
);
  int lag;
  initial begin
    busy = 1'b0;
    ack_n = 1'b1;
    got = 8'h00;
    got_cmd = 1'b0;
    n_got = 0;
    n_sent = 0;
    lag = 0;
  end
  // released lines show the inverse of got while ack_n is high, the offered reverse byte while it is low
  assign pd_in = !pd_oe_n ? pd_out : (ack_n ? ~got : 8'(rv_base + n_sent));
  // reverse byte offered, freed on host ack
  always @(posedge clk_sys) begin
    if (ack_n && ctrl_n[1] && pd_oe_n && n_sent < int'(rev_n)) begin
      ack_n <= 1'b0;
    end else if (!ack_n && !ctrl_n[1]) begin
      ack_n <= 1'b1;
      n_sent <= n_sent + 1;
    end
  end
  // busy reply to strobe, prompt or slow
  always @(posedge clk_sys) begin
    if (!ctrl_n[0] && !busy) begin
      lag <= lag + 1;
      if (lag >= (slow ? 6 : 0)) begin
        busy <= 1'b1;
        got <= pd_out;
        got_cmd <= !ctrl_n[1];
        n_got <= n_got + 1;
        lag <= 0;
      end
    end else if (ctrl_n[0] && busy) begin
      busy <= 1'b0;
    end
  end
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ps
`include "ecpmc_cfg.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("wrong value t=%0t %h vs %h", $time, a, b); end end
module tb_top;
  logic clk_sys = 0, reset_n = 0, bus_wr = 0, bus_rd = 0, dma_tc = 0;
  logic epp_option = 0, fault_n = 1, slow = 0, irq_prev = 0;
  logic [10:0] bus_addr = 0;
  logic [7:0] bus_wdata = 0, rd, got, bus_rdata_q, pd_in, pd_out_q;
  logic [7:0] q[4];
  logic [3:0] threshold_setting = 0, ctrl_n_q;
  logic dma_req_q, pd_oe_n_q, busy, ack_n, ctrl_oc_q, epp_sel_q, irq_q, got_cmd;
  logic dma_ack = 0;
  logic [7:0] rv_base = 0;
  logic [3:0] rev_n = 0;
  logic [2:0] ml[6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h7};
  int errors = 0, comparisons = 0, irqs = 0, n_got, n_sent, cyc = 0, base;
  always #2.5 clk_sys = ~clk_sys;
  ecpmc_top #(.DEPTH(4)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
    .dma_ack(dma_ack), .dma_tc(dma_tc), .dma_req_q(dma_req_q), .epp_option(epp_option),
    .threshold_setting(threshold_setting), .pd_in(pd_in), .pd_out_q(pd_out_q),
    .pd_oe_n_q(pd_oe_n_q), .busy(busy), .ack_n(ack_n), .fault_n(fault_n),
    .ctrl_n_q(ctrl_n_q), .ctrl_oc_q(ctrl_oc_q), .epp_sel_q(epp_sel_q), .irq_q(irq_q));
  ecpmc_periph i_periph (.clk_sys(clk_sys), .slow(slow), .ctrl_n(ctrl_n_q),
    .pd_out(pd_out_q), .pd_oe_n(pd_oe_n_q), .busy(busy), .ack_n(ack_n), .pd_in(pd_in),
    .got(got), .n_got(n_got), .rv_base(rv_base), .rev_n(rev_n), .got_cmd(got_cmd),
    .n_sent(n_sent));
  // ==========
  // helpers
  function automatic logic [7:0] ecr_val(input logic [2:0] m, input logic [1:0] fe);
    return {m, 3'b101, fe};
  endfunction
  function automatic logic [7:0] rev_exp(input int k);
    return 8'(rv_base + k);
  endfunction
  task automatic close_out;
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
  endtask
  task automatic rdb(input logic [10:0] a);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    #1 rd = bus_rdata_q;
  endtask
  task automatic set_mode(input logic [7:0] d);
    wr(`ECPMC_OFS_ECR, d);
    idle(3);
  endtask
  task automatic set_fault(input logic v);
    @(posedge clk_sys);
    fault_n <= v;
    idle(8);
  endtask
  // ==========
  // interrupt watch and hang limit
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    irq_prev <= irq_q;
    if (irq_q === 1'b1) irqs <= irqs + 1;
    if (reset_n) `CHK(irq_q & irq_prev, 1'b0)
    if (cyc == 20000) begin
      errors++;
      close_out;
    end
  end
  // ==========
  // main sequence
  initial begin
    void'($urandom(32'h5454));
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    slow <= 1'b1;
    rdb(`ECPMC_OFS_ECR);
    `CHK(rd, `ECPMC_ECR_RST)
    // walk every mode; jumps between extended modes are refused
    foreach (ml[i]) begin
      set_mode({ml[i], 5'h14});
      rdb(`ECPMC_OFS_ECR);
      `CHK(rd, ecr_val(ml[i], 2'b01))
      `CHK(ctrl_oc_q, 1'b0)
      if (ml[i] > 3'h1) begin
        set_mode(8'hb4);
        rdb(`ECPMC_OFS_ECR);
        `CHK(rd[7:5], ml[i])
      end
      set_mode(8'h14);
      `CHK(ctrl_oc_q, 1'b1)
    end
    // test fifo: fill past full, drain past empty
    set_mode(8'hd4);
    base = n_got;
    for (int i = 0; i < 4; i++) begin
      q[i] = 8'($urandom);
      wr(`ECPMC_OFS_FIFO, q[i]);
    end
    wr(`ECPMC_OFS_FIFO, ~q[0]);
    rdb(`ECPMC_OFS_ECR);
    `CHK(rd[1:0], 2'b10)
    for (int i = 0; i < 4; i++) begin
      rdb(`ECPMC_OFS_FIFO);
      `CHK(rd, q[i])
    end
    rdb(`ECPMC_OFS_FIFO);
    `CHK(rd, q[3])
    rdb(`ECPMC_OFS_ECR);
    `CHK(rd[1:0], 2'b01)
    `CHK(n_got, base)
    // free space service at the threshold boundary
    for (int t = 3; t < 5; t++) begin
      @(posedge clk_sys);
      threshold_setting <= 4'(t);
      base = irqs;
      wr(`ECPMC_OFS_ECR, 8'hc0);
      idle(4);
      `CHK(irqs - base, int'(t == 3))
      rdb(`ECPMC_OFS_ECR);
      `CHK(rd[2], t == 3)
      wr(`ECPMC_OFS_ECR, 8'hc4);
      idle(4);
      `CHK(irqs - base, int'(t == 3))
    end
    // dma request, then terminal count
    base = irqs;
    wr(`ECPMC_OFS_ECR, 8'hc8);
    idle(3);
    `CHK(dma_req_q, 1'b1)
    // dma write lands in the fifo whatever the address
    q[1] = 8'($urandom);
    @(posedge clk_sys);
    dma_ack <= 1'b1;
    bus_wdata <= q[1];
    bus_wr <= 1'b1;
    @(posedge clk_sys);
    dma_ack <= 1'b0;
    bus_wr <= 1'b0;
    rdb(`ECPMC_OFS_FIFO);
    `CHK(rd, q[1])
    @(posedge clk_sys);
    dma_tc <= 1'b1;
    @(posedge clk_sys);
    dma_tc <= 1'b0;
    idle(3);
    `CHK(irqs - base, 1)
    `CHK(dma_req_q, 1'b0)
    set_mode(8'h14);
    // forward transfer in fifo mode
    set_mode(8'h54);
    base = n_got;
    q[0] = 8'($urandom);
    wr(`ECPMC_OFS_FIFO, q[0]);
    for (int i = 0; i < 300 && n_got == base; i++) @(posedge clk_sys);
    `CHK(got, q[0])
    idle(20);
    rdb(`ECPMC_OFS_ECR);
    `CHK(rd[0], 1'b1)
    set_mode(8'h14);
    // fault interrupt in ecp mode
    // direction strobe autofeed cleared
    wr(`ECPMC_OFS_CTRL, 8'h00);
    set_mode(8'h74);
    base = irqs;
    set_fault(1'b0);
    `CHK(irqs - base, 0)
    set_mode(8'h64);
    `CHK(irqs - base, 1)
    set_fault(1'b1);
    set_fault(1'b0);
    `CHK(irqs - base, 2)
    set_fault(1'b1);
    // ecp forward: command byte, then data byte
    q[0] = 8'($urandom);
    q[1] = 8'($urandom);
    for (int k = 0; k < 2; k++) begin
      base = n_got;
      wr(k == 0 ? `ECPMC_OFS_DATA : `ECPMC_OFS_FIFO, q[k]);
      for (int i = 0; i < 300 && n_got == base; i++) @(posedge clk_sys);
      `CHK(got, q[k])
      `CHK(got_cmd, k == 0)
      idle(20);
    end
    set_mode(8'h14);
    // configuration mode
    set_mode(8'hf4);
    rdb(`ECPMC_OFS_CFGA);
    `CHK(rd, `ECPMC_CFGA_VAL)
    rdb(`ECPMC_OFS_CFGB);
    `CHK(rd[7], 1'b0)
    set_mode(8'h14);
    for (int o = 0; o < 2; o++) begin
      @(posedge clk_sys);
      epp_option <= o[0];
      set_mode(8'h94);
      `CHK(epp_sel_q, o[0])
      set_mode(8'h14);
    end
    // reverse direction last, so no cleanup is needed
    set_mode(8'h34);
    wr(`ECPMC_OFS_CTRL, 8'h20);
    idle(6);
    `CHK(pd_oe_n_q, 1'b1)
    rdb(`ECPMC_OFS_DATA);
    `CHK(rd, ~got)
    set_mode(8'hd4);
    @(posedge clk_sys);
    threshold_setting <= 4'h1;
    base = irqs;
    wr(`ECPMC_OFS_FIFO, 8'($urandom));
    wr(`ECPMC_OFS_ECR, 8'hc0);
    idle(4);
    `CHK(irqs - base, 0)
    wr(`ECPMC_OFS_FIFO, 8'($urandom));
    idle(4);
    `CHK(irqs - base, 1)
    // ecp reverse: fill, drain, leave with one byte left over
    set_mode(8'h34);
    set_mode(8'h74);
    @(posedge clk_sys);
    rv_base <= 8'($urandom);
    rev_n <= 4'h5;
    for (int i = 0; i < 600 && n_sent < 4; i++) @(posedge clk_sys);
    idle(20);
    rdb(`ECPMC_OFS_ECR);
    `CHK(rd[1:0], 2'b10)
    for (int k = 0; k < 4; k++) begin
      rdb(`ECPMC_OFS_FIFO);
      `CHK(rd, rev_exp(k))
    end
    for (int i = 0; i < 300 && n_sent < 5; i++) @(posedge clk_sys);
    set_mode(8'h34);
    rdb(`ECPMC_OFS_ECR);
    `CHK(rd[1:0], 2'b01)
    `CHK(ctrl_n_q[1], 1'b1)
    close_out;
  end
endmodule
